// [fcdf_top.sv]
// Frequency and current detection flags with APB registers.
// Assumes synchronous drive inputs; current in percent of rated.
// Summary of operation
// - Up-to-frequency flag asserts when output frequency reaches set frequency band.
// - Band is plus/minus sensitivity percent of set frequency, 0 to 100.
// - Frequency-reached flag asserts at or above forward threshold, default 6 Hz.
// - Non-sentinel reverse threshold is used during reverse rotation.
// - Reverse threshold at sentinel 9999 makes reverse use forward threshold.
// - DC injection braking forces both frequency flags off.
// - Up-to-frequency compares the frequency before slip compensation.
// - Up-to-frequency routes to terminals for codes 1 and 101.
// - Codes 0-99 conduct when active; 100-199 do not conduct when active.
// - Overcurrent level is percent of rated current, 0 to 200, default 150.
// - Overcurrent asserts after current stays above level for the delay.
// - Overcurrent delay is 0 to 10 seconds, default 0.
// - Overcurrent flag holds about 100 ms once asserted.
// - Zero-current asserts after current stays below level longer than time.
// - Zero-current level of zero disables zero-current detection.
// - Overcurrent routes to terminals for codes 12 and 112.
// - Zero-current routes to terminals for codes 13 and 113.
// - Current detection stays active during offline auto-tuning.
// - Current flags respond within roughly 0.1 seconds.
// Register map, one 32-bit word each, data in the low bits
// 0x00 up_to_freq_sensitivity, percent of set frequency
// 0x04 fwd_freq_threshold, 0.1 Hz steps
// 0x08 rev_freq_threshold, 9999 means follow the forward threshold
// 0x0C overcurrent_level, percent of rated current
// 0x10 overcurrent_delay, 10 ms steps
// 0x14 zero_current_level, percent of rated current, 0 disables
// 0x18 zero_current_time, 10 ms steps
// 0x1C to 0x30 terminal function codes for terminals 0 to 5
// 0x34 status, read only: flags in bits 3:0, terminals in bits 13:8
// Terminal 0 is the physical output terminal; 1 to 5 are virtual terminals.
// Settings are not range-checked; software keeps them inside their ranges.
// Unaligned or unmapped accesses answer with pslverr and change nothing.
// Frequencies are in 0.1 Hz steps and currents in percent of rated.
// Operation means running or offline auto-tuning.
`timescale 1ns/1ps
`default_nettype none

module fcdf_top
    import fcdf_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] out_freq,
    input wire logic [15:0] set_freq,
    input wire logic reverse,
    input wire logic running,
    input wire logic dc_brake,
    input wire logic autotune,
    input wire logic [7:0] out_current,
    output logic up_to_freq_flag,
    output logic freq_reached_flag,
    output logic overcurrent_flag,
    output logic zero_current_flag,
    output logic physical_output_terminal,
    output logic [NUM_TERMS-2:0] virtual_terminals
);

    // ==================================================================
    // State
    // One packed record holds every register of the block
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [6:0] sens;
        logic [15:0] fwd_thr;
        logic [15:0] rev_thr;
        logic [7:0] oc_level;
        logic [9:0] oc_delay;
        logic [7:0] zc_level;
        logic [6:0] zc_time;
        logic [NUM_TERMS-1:0][7:0] codes;
        logic [31:0] div_cnt;
        logic tick;
        logic [9:0] oc_cnt;
        logic [3:0] oc_hold;
        logic [7:0] zc_cnt;
        logic su;
        logic fu;
        logic oc;
        logic zc;
        logic [NUM_TERMS-1:0] term;
    } fcdf_state_type;

    fcdf_state_type s_r;
    fcdf_state_type s_nxt;

    // ==================================================================
    // Decoding shared by every terminal
    // A code in the inverted range is folded back onto its base code,
    // so each flag is decoded once whatever the polarity.
    function automatic logic fcdf_route(input logic [7:0] code, input logic su,
                                        input logic oc, input logic zc);
        logic neg;
        logic [7:0] base;
        logic hit;
        logic act;
        neg = (code >= NEG_BASE) && (code <= NEG_LIMIT);
        base = neg ? code - NEG_BASE : code;
        hit = 1'b1;
        act = 1'b0;
        case (base)
            FN_UP_TO_FREQ: act = su;
            FN_OVERCURRENT: act = oc;
            FN_ZERO_CURRENT: act = zc;
            default: hit = 1'b0;
        endcase
        // Unassigned or unknown codes leave the terminal off
        // An inverted code with no function stays off as well
        return hit && (neg ? ~act : act);
    endfunction

    // Nonzero when the address is aligned and inside the map;
    // status is the last word, everything above it is refused
    function automatic logic [31:0] fcdf_addr_ok(input logic [7:0] addr);
        logic [31:0] ok;
        ok = 32'h0;
        if (addr[1:0] == 2'b00 && addr <= STATUS_OFS)
        begin
            ok = 32'h1;
        end
        return ok;
    endfunction

    // ==================================================================
    // Comparison terms
    // Raw compare results, before registering; only oc_qual depends on timing
    logic [23:0] freq_diff;
    logic [23:0] band_lhs;
    logic [23:0] band_rhs;
    logic [15:0] fu_thr;
    logic detect_on;
    logic over_cond;
    logic under_cond;
    logic su_raw;
    logic fu_raw;
    logic oc_qual;

    // Wide products avoid overflow at 400 Hz and 100 percent
    // The band test is cross-multiplied so no divider is needed;
    // the cost is two small multipliers on the control clock.
    always_comb
    begin
        // out_freq is taken before slip compensation
        freq_diff = (out_freq >= set_freq) ? {8'h00, out_freq - set_freq}
                                           : {8'h00, set_freq - out_freq};
        band_lhs = 24'(freq_diff * 24'(PCT_FULL));
        band_rhs = 24'({17'h00000, s_r.sens} * {8'h00, set_freq});
        su_raw = (band_lhs <= band_rhs) && !dc_brake;
        fu_thr = (reverse && s_r.rev_thr != REV_SENTINEL) ? s_r.rev_thr
                                                          : s_r.fwd_thr;
        fu_raw = (out_freq >= fu_thr) && !dc_brake;
        detect_on = running || autotune;
        over_cond = detect_on && (out_current > s_r.oc_level);
        under_cond = detect_on && (s_r.zc_level != 8'h00)
                     && (out_current < s_r.zc_level);
        oc_qual = over_cond && (s_r.oc_cnt >= s_r.oc_delay);
    end

    // ==================================================================
    // Next state
    always_comb
    begin
        s_nxt = s_r;

        // APB slave: one wait-free access phase, answer prepared in setup
        // The answer is latched from the setup cycle, so read data never
        // depends on the address moving later in the access phase.
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (psel && !penable)
        begin
            s_nxt.pready = 1'b1;
            s_nxt.pslverr = (fcdf_addr_ok(paddr) == 32'h0);
            s_nxt.prdata = 32'h0;
            if (!pwrite)
            begin
                case (paddr)
                    SENS_OFS: s_nxt.prdata = {25'h0, s_r.sens};
                    FWD_THR_OFS: s_nxt.prdata = {16'h0, s_r.fwd_thr};
                    REV_THR_OFS: s_nxt.prdata = {16'h0, s_r.rev_thr};
                    OC_LEVEL_OFS: s_nxt.prdata = {24'h0, s_r.oc_level};
                    OC_DELAY_OFS: s_nxt.prdata = {22'h0, s_r.oc_delay};
                    ZC_LEVEL_OFS: s_nxt.prdata = {24'h0, s_r.zc_level};
                    ZC_TIME_OFS: s_nxt.prdata = {25'h0, s_r.zc_time};
                    STATUS_OFS: s_nxt.prdata = {18'h0, s_r.term, 4'h0,
                                                s_r.zc, s_r.oc, s_r.fu, s_r.su};
                    default:
                    begin
                        for (int i = 0; i < NUM_TERMS; i++)
                        begin
                            if (paddr == 8'(TERM_CODE_OFS + 8'(4 * i)))
                            begin
                                s_nxt.prdata = {24'h0, s_r.codes[i]};
                            end
                        end
                    end
                endcase
            end
        end

        // Writes take effect at the completing edge only
        if (psel && penable && s_r.pready && pwrite && !s_r.pslverr)
        begin
            case (paddr)
                SENS_OFS: s_nxt.sens = pwdata[6:0];
                FWD_THR_OFS: s_nxt.fwd_thr = pwdata[15:0];
                REV_THR_OFS: s_nxt.rev_thr = pwdata[15:0];
                OC_LEVEL_OFS: s_nxt.oc_level = pwdata[7:0];
                OC_DELAY_OFS: s_nxt.oc_delay = pwdata[9:0];
                ZC_LEVEL_OFS: s_nxt.zc_level = pwdata[7:0];
                ZC_TIME_OFS: s_nxt.zc_time = pwdata[6:0];
                default:
                begin
                    for (int i = 0; i < NUM_TERMS; i++)
                    begin
                        if (paddr == 8'(TERM_CODE_OFS + 8'(4 * i)))
                        begin
                            s_nxt.codes[i] = pwdata[7:0];
                        end
                    end
                end
            endcase
        end

        // 10 ms time base; every timer counts in these ticks
        // Timers only move on a tick, so a qualify time can start up to
        // one tick late; this jitter is far inside the 0.1 s response.
        s_nxt.tick = 1'b0;
        if (s_r.div_cnt >= 32'(TICK_LEN - 1))
        begin
            s_nxt.div_cnt = 32'h0;
            s_nxt.tick = 1'b1;
        end
        else
        begin
            s_nxt.div_cnt = s_r.div_cnt + 32'h1;
        end

        // Overcurrent qualification, restarting whenever current drops
        // The counter stops at the delay so it cannot wrap during a long
        // overload and drop the flag by mistake.
        if (!over_cond)
        begin
            s_nxt.oc_cnt = 10'h000;
        end
        else if (s_r.tick && s_r.oc_cnt < s_r.oc_delay)
        begin
            s_nxt.oc_cnt = s_r.oc_cnt + 10'h001;
        end

        // Hold keeps the flag up for the stretch after the last qualify
        // A second overload during the hold simply reloads it.
        if (oc_qual)
        begin
            s_nxt.oc_hold = 4'(OC_HOLD_TICKS);
        end
        else if (s_r.tick && s_r.oc_hold != 4'h0)
        begin
            s_nxt.oc_hold = s_r.oc_hold - 4'h1;
        end

        // Zero-current counter saturates one past the time to mean longer
        // Stopping or a level of zero clears it, so a new run starts fresh.
        if (!under_cond)
        begin
            s_nxt.zc_cnt = 8'h00;
        end
        else if (s_r.tick && s_r.zc_cnt <= {1'b0, s_r.zc_time})
        begin
            s_nxt.zc_cnt = s_r.zc_cnt + 8'h01;
        end

        // Flags sample each cycle, well inside the 0.1 s response
        // Braking and the frequency compares act within one cycle.
        s_nxt.su = su_raw;
        s_nxt.fu = fu_raw;
        s_nxt.oc = oc_qual || (s_r.oc_hold != 4'h0);
        s_nxt.zc = under_cond && (s_r.zc_cnt > {1'b0, s_r.zc_time});

        // Terminal routing uses registered flags for a clean one-cycle lag
        // Every terminal sees the same flag values in a given cycle,
        // so two terminals on one function never disagree.
        for (int i = 0; i < NUM_TERMS; i++)
        begin
            s_nxt.term[i] = fcdf_route(s_r.codes[i], s_r.su, s_r.oc, s_r.zc);
        end
    end

    // ==================================================================
    // State register
    // Reset restores the default settings; every counter and flag
    // starts at zero, so no flag can show before its inputs are seen.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r <= '0;
            s_r.sens <= SENS_RST;
            s_r.fwd_thr <= FWD_THR_RST;
            s_r.rev_thr <= REV_THR_RST;
            s_r.oc_level <= OC_LEVEL_RST;
            s_r.oc_delay <= OC_DELAY_RST;
            s_r.zc_level <= ZC_LEVEL_RST;
            s_r.zc_time <= ZC_TIME_RST;
            s_r.codes <= {NUM_TERMS{TERM_CODE_RST}};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ==================================================================
    // Outputs straight from the state register
    // No output passes through logic after the flip-flops.
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign up_to_freq_flag = s_r.su;
    assign freq_reached_flag = s_r.fu;
    assign overcurrent_flag = s_r.oc;
    assign zero_current_flag = s_r.zc;
    assign physical_output_terminal = s_r.term[0];
    assign virtual_terminals = s_r.term[NUM_TERMS-1:1];

endmodule

`default_nettype wire

// [fcdf_pkg.sv]
// Constants for the frequency and current detection flag block.
// Assumes a 25 MHz APB clock and frequencies in 0.1 Hz steps.
`default_nettype none

package fcdf_pkg;

    // ==================================================================
    // Clock and time base
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned TICK_MS = 10;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned OC_HOLD_MS = 100;
    localparam int unsigned OC_HOLD_TICKS = OC_HOLD_MS / TICK_MS;
    localparam int unsigned RESPONSE_MS = 100;

    // ==================================================================
    // Register byte offsets
    localparam logic [7:0] SENS_OFS = 8'h00;
    localparam logic [7:0] FWD_THR_OFS = 8'h04;
    localparam logic [7:0] REV_THR_OFS = 8'h08;
    localparam logic [7:0] OC_LEVEL_OFS = 8'h0C;
    localparam logic [7:0] OC_DELAY_OFS = 8'h10;
    localparam logic [7:0] ZC_LEVEL_OFS = 8'h14;
    localparam logic [7:0] ZC_TIME_OFS = 8'h18;
    localparam logic [7:0] TERM_CODE_OFS = 8'h1C;
    localparam logic [7:0] STATUS_OFS = 8'h34;
    localparam int unsigned NUM_TERMS = 6;

    // ==================================================================
    // Reset values and limits
    localparam logic [6:0] SENS_RST = 7'h0A;
    localparam logic [15:0] FWD_THR_RST = 16'h003C;
    localparam logic [15:0] REV_SENTINEL = 16'h270F;
    localparam logic [15:0] REV_THR_RST = 16'h270F;
    localparam logic [7:0] OC_LEVEL_RST = 8'h96;
    localparam logic [9:0] OC_DELAY_RST = 10'h000;
    localparam logic [7:0] ZC_LEVEL_RST = 8'h05;
    localparam logic [6:0] ZC_TIME_RST = 7'h32;
    localparam logic [7:0] TERM_CODE_RST = 8'h63;

    // ==================================================================
    // Terminal function codes
    localparam logic [7:0] NEG_BASE = 8'h64;
    localparam logic [7:0] NEG_LIMIT = 8'hC7;
    localparam logic [7:0] FN_UP_TO_FREQ = 8'h01;
    localparam logic [7:0] FN_OVERCURRENT = 8'h0C;
    localparam logic [7:0] FN_ZERO_CURRENT = 8'h0D;
    localparam logic [7:0] PCT_FULL = 8'h64;

endpackage

`default_nettype wire

// [fcdf_properties.sv]
// Port checker for the detection flag block.
// Assumes binding to fcdf_top; one clock domain, async low reset.
`timescale 1ns/1ps
`default_nettype none
module fcdf_properties
#(
    parameter int unsigned TICK_LEN = 10
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] out_freq,
    input wire logic [15:0] set_freq,
    input wire logic running,
    input wire logic dc_brake,
    input wire logic autotune,
    input wire logic up_to_freq_flag,
    input wire logic freq_reached_flag,
    input wire logic overcurrent_flag,
    input wire logic zero_current_flag
);
    // ==================================================================
    // Flag and bus relations
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    dc_block_a: assert property (dc_brake |=> !up_to_freq_flag && !freq_reached_flag)
        else $error("frequency flag set while braking");
    utf_match_a: assert property (out_freq == set_freq && !dc_brake |=> up_to_freq_flag)
        else $error("up to frequency missing at exact match");
    fu_top_a: assert property (out_freq == 16'hFFFF && !dc_brake |=> freq_reached_flag)
        else $error("frequency reached missing at full scale");
    oc_hold_a: assert property ($rose(overcurrent_flag) |=> overcurrent_flag [*8])
        else $error("overcurrent flag dropped too soon");
    oc_cause_a: assert property ($rose(overcurrent_flag) |-> $past(running) || $past(autotune))
        else $error("overcurrent flag rose outside operation");
    zc_cause_a: assert property ($rose(zero_current_flag) |-> $past(running) || $past(autotune))
        else $error("zero current flag rose outside operation");
    zc_idle_a: assert property (!running && !autotune |=> !zero_current_flag)
        else $error("zero current flag set while stopped");
    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer in first access cycle");
    apb_refuse_a: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("unaligned access not refused");
endmodule
`default_nettype wire

// [fcdf_brake_model.sv]
// Brake actuator fed from one output terminal.
// Assumes the terminal is a level that is high while it conducts.
`timescale 1ns/1ps
`default_nettype none
module fcdf_brake_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic terminal,
    output logic brake_closed_r
);
    // ==================================================================
    // Actuator
    // Coil follows the contact one clock late, as a relay would
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            brake_closed_r <= 1'b0;
        else
            brake_closed_r <= terminal;
    end
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the detection flag block.
// Assumes fcdf_pkg compiled first; tick shortened to 10 clocks.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import fcdf_pkg::*;
();
    // ==================================================================
    // Stimulus state
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic reverse = 1'b0, running = 1'b0, dc_brake = 1'b0, autotune = 1'b0;
    logic [7:0] paddr = 8'h00, out_current = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [15:0] out_freq = 16'h0, set_freq = 16'h0;
    logic pready, pslverr, su, fu, oc, zc, term0, brake, e;
    logic [4:0] vterm;
    logic [3:0] fl;
    int error_cnt = 0, checks_done = 0, cyc = 0, n;
    integer seed = 32'h0F3C;
    assign fl = {zc, oc, fu, su};
    fcdf_top #(.TICK_LEN(10)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .out_freq(out_freq), .set_freq(set_freq),
        .reverse(reverse), .running(running), .dc_brake(dc_brake), .autotune(autotune),
        .out_current(out_current), .up_to_freq_flag(su), .freq_reached_flag(fu),
        .overcurrent_flag(oc), .zero_current_flag(zc), .physical_output_terminal(term0),
        .virtual_terminals(vterm));
    fcdf_brake_model brk (.pclk(pclk), .presetn(presetn), .terminal(term0),
        .brake_closed_r(brake));
    always #20 pclk = ~pclk;
    // Hang guard, well above the roughly nine hundred clocks the run needs
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            error_cnt = error_cnt + 1;
            close_out();
        end
    end
    // ==================================================================
    // Helpers
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks_done = checks_done + 1;
        if (got !== ex)
        begin
            error_cnt = error_cnt + 1;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // One APB transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n = n + 1;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Clocks a flag spends at level v, capped
    task automatic span(input int b, input logic v, input int lim);
        n = 0;
        while (fl[b] === v && n < lim)
        begin
            @(posedge pclk);
            n = n + 1;
        end
    endtask
    function automatic logic su_exp(input logic [15:0] o, s, input logic [6:0] sn);
        int unsigned d;
        d = (o > s) ? 32'(o - s) : 32'(s - o);
        return d * 100 <= 32'(sn) * s;
    endfunction
    function automatic logic fu_exp(input logic [15:0] o, ft, rt, input logic rv);
        return o >= ((rv && rt != REV_SENTINEL) ? rt : ft);
    endfunction
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==================================================================
    // Main sequence
    initial
    begin
        logic [31:0] rtab [7] = '{SENS_RST, FWD_THR_RST, REV_THR_RST, OC_LEVEL_RST,
            OC_DELAY_RST, ZC_LEVEL_RST, ZC_TIME_RST};
        logic [7:0] codes [7] = '{8'h01, 8'h65, 8'h0C, 8'h70, 8'h0D, 8'h71, 8'h63};
        logic [6:0] texp = 7'h29;
        logic [15:0] ft, rt, s, o;
        logic [6:0] sn;
        logic rv;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 13; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", (i < 7) ? rtab[i] : 32'(TERM_CODE_RST), q);
        end
        apb(1'b1, 8'h38, 32'hFF);
        chk("unmapped refusal", 32'h1, 32'(e));
        apb(1'b0, 8'h02, 32'h0);
        chk("unaligned refusal", 32'h1, 32'(e));
        // Known flags: on frequency, no current event; walk the codes
        running <= 1'b1;
        out_current <= 8'h64;
        set_freq <= 16'h0258;
        out_freq <= 16'h0258;
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b1, TERM_CODE_OFS, 32'(codes[i]));
            apb(1'b1, TERM_CODE_OFS + 8'h14, 32'(codes[i]));
            repeat (3) @(posedge pclk);
            chk("terminal 0", 32'(texp[i]), 32'(term0));
            chk("terminal 5", 32'(texp[i]), 32'(vterm[4]));
        end
        // Random frequencies with band and threshold corners
        for (int i = 0; i < 40; i++)
        begin
            sn = (i == 1) ? 7'h00 : 7'($unsigned($random(seed)) % 101);
            ft = 16'($unsigned($random(seed)) % 4001);
            rt = (i % 3 == 0) ? REV_SENTINEL : 16'($unsigned($random(seed)) % 4001);
            s = 16'($unsigned($random(seed)) % 4001);
            o = (i % 2) ? s + 16'(32'(s) * sn / 100) : 16'($unsigned($random(seed)) % 4001);
            o = (i == 5) ? 16'hFFFF : (i == 6) ? ft : o;
            rv = 1'($random(seed));
            apb(1'b1, SENS_OFS, 32'(sn));
            apb(1'b1, FWD_THR_OFS, 32'(ft));
            apb(1'b1, REV_THR_OFS, 32'(rt));
            set_freq <= s;
            out_freq <= o;
            reverse <= rv;
            dc_brake <= (i % 4 == 3);
            repeat (2) @(posedge pclk);
            chk("up to freq", 32'(!dc_brake && su_exp(o, s, sn)), 32'(su));
            chk("freq reached", 32'(!dc_brake && fu_exp(o, ft, rt, rv)), 32'(fu));
        end
        dc_brake <= 1'b0;
        // Overcurrent: short burst restarts the timer, then qualify and hold
        apb(1'b1, OC_DELAY_OFS, 32'h3);
        apb(1'b1, TERM_CODE_OFS, 32'h0C);
        out_current <= 8'hA0;
        repeat (15) @(posedge pclk);
        out_current <= 8'h64;
        repeat (5) @(posedge pclk);
        chk("oc early", 32'h0, 32'(oc));
        out_current <= 8'hA0;
        span(2, 1'b0, 80);
        chk("oc delay in range", 32'h1, 32'(n >= 20 && n <= 42));
        @(posedge pclk);
        chk("oc terminal", 32'h1, 32'(term0));
        out_current <= 8'h64;
        span(2, 1'b1, 200);
        chk("oc hold in range", 32'h1, 32'(n >= 88 && n <= 103));
        // Zero current: qualify, brake closes, tuning keeps it, level 0 disables
        apb(1'b1, ZC_TIME_OFS, 32'h5);
        apb(1'b1, TERM_CODE_OFS, 32'h0D);
        out_current <= 8'h00;
        span(3, 1'b0, 120);
        chk("zc delay in range", 32'h1, 32'(n >= 45 && n <= 72));
        repeat (3) @(posedge pclk);
        chk("brake closed", 32'h1, 32'(brake));
        running <= 1'b0;
        autotune <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("zc in tuning", 32'h1, 32'(zc));
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("status zc bit", 32'h1, 32'(q[3]));
        autotune <= 1'b0;
        apb(1'b1, ZC_LEVEL_OFS, 32'h0);
        running <= 1'b1;
        repeat (100) @(posedge pclk);
        chk("zc disabled", 32'h0, 32'(zc));
        close_out();
    end
endmodule
bind fcdf_top fcdf_properties #(.TICK_LEN(TICK_LEN)) props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .out_freq(out_freq), .set_freq(set_freq), .running(running), .dc_brake(dc_brake),
    .autotune(autotune), .up_to_freq_flag(up_to_freq_flag),
    .freq_reached_flag(freq_reached_flag), .overcurrent_flag(overcurrent_flag),
    .zero_current_flag(zero_current_flag));
`default_nettype wire
